// ---- tws_serial_port.sv ----
/*
 * tws_serial_port: three-wire clocked serial port moving 8-bit frames as
 * master (divided system clock) or slave (clock from the serial clock pin).
 * Assumes control bits arrive as static ports and strobes are one clk_sys
 * cycle wide; the serial clock pin also feeds the link clock port.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_serial_port
    import tws_pkg::*;
#(
    parameter int DIV_W = 7
)(
    // system clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    // link clock (serial clock pin seen as a clock)
    input  wire logic           clk_link,
    // configuration
    input  wire logic           serial_enable_bit,
    input  wire logic           transmit_mode_bit,
    input  wire logic           first_bit_select,
    input  wire logic           clock_polarity_bit,
    input  wire logic           data_phase_bit,
    input  wire logic [2:0]     clock_select,
    // data access strobes
    input  wire logic           tx_write,
    input  wire logic [7:0]     tx_data,
    input  wire logic           rx_read,
    input  wire logic           irq_clear,
    // status and data
    output logic [7:0]          serial_shift_register,
    output logic                transfer_active_flag,
    output logic                transfer_done_irq_flag,
    // serial pins
    input  wire logic           serial_in_pin,
    output logic                serial_clock_out,
    output logic                serial_clock_oe_n,
    output logic                serial_out_pin,
    output logic                serial_out_oe_n
);

    typedef struct packed {
        tws_state_e     st;
        logic [7:0]     tx_buf;
        logic [7:0]     sio;
        logic           out_latch;
        logic           so;
        logic           so_oe_n;
        logic           sck;
        logic           sck_oe_n;
        logic           active;
        logic           irq;
        logic           loaded;
        logic [3:0]     ncap;
        logic [4:0]     nedge;
        logic [DIV_W-1:0] div;
        logic           si_s1;
        logic           si_s2;
        logic           rt_s1;
        logic           rt_s2;
        logic           rt_p;
        logic           ft_s1;
        logic           ft_s2;
        logic           ft_p;
    } tws_state_s;

    tws_state_s q;
    tws_state_s d;
    tws_cfg_s   cfg;

    logic rise_tog;
    logic rise_si;
    logic fall_tog;
    logic fall_si;
    logic clk_link_n;

    assign cfg = '{enable: serial_enable_bit, trmd: transmit_mode_bit,
                   dir: first_bit_select, ckp: clock_polarity_bit,
                   dap: data_phase_bit, cks: clock_select};

    // falling edges of the link clock drive a second catcher
    assign clk_link_n = ~clk_link;

    tws_edge_catch u_rise (
        .clk_link      (clk_link),
        .rstn          (rstn),
        .serial_in_pin (serial_in_pin),
        .tog_o         (rise_tog),
        .si_o          (rise_si)
    );

    tws_edge_catch u_fall (
        .clk_link      (clk_link_n),
        .rstn          (rstn),
        .serial_in_pin (serial_in_pin),
        .tog_o         (fall_tog),
        .si_o          (fall_si)
    );

    // first bit of a byte in the selected order
    function automatic logic first_of(input logic [7:0] b, input logic lsb);
        first_of = lsb ? b[0] : b[7];
    endfunction

    always_comb begin
        logic             slave;
        logic             ev_rise;
        logic             ev_fall;
        logic             ev_lead;
        logic             ev_trail;
        logic             ev_cap;
        logic             ev_launch;
        logic             si_now;
        logic             start;
        logic             done;
        logic [7:0]       src;
        logic [DIV_W-1:0] half;

        d         = q;
        slave     = 1'b0;
        ev_rise   = 1'b0;
        ev_fall   = 1'b0;
        ev_lead   = 1'b0;
        ev_trail  = 1'b0;
        ev_cap    = 1'b0;
        ev_launch = 1'b0;
        si_now    = 1'b0;
        start     = 1'b0;
        done      = 1'b0;
        src       = TWS_BYTE_RESET;
        half      = TWS_DIV_ONE << cfg.cks;

        // pin and link synchronisers
        // link edges cross as toggles through two flops; the serial in
        // sample beside each toggle holds for a whole link period,
        // so it is read directly only after its toggle has arrived
        // master receive reads serial in two cycles late through the
        // pin flops: at divide by four the new bit is not yet visible,
        // so receiving at that rate needs divide by eight or slower
        d.si_s1 = serial_in_pin;
        d.si_s2 = q.si_s1;
        d.rt_s1 = rise_tog;
        d.rt_s2 = q.rt_s1;
        d.rt_p  = q.rt_s2;
        d.ft_s1 = fall_tog;
        d.ft_s2 = q.ft_s1;
        d.ft_p  = q.ft_s2;

        // slave on code 111
        // slave edges show up about three cycles late, so a link half
        // period under about five system cycles is too fast to launch on
        slave = (cfg.cks == TWS_CKS_SLAVE);

        // buffer write starts in transmit mode
        if (q.st == TWS_ST_IDLE && cfg.enable) begin
            start = (tx_write && cfg.trmd) || (rx_read && !cfg.trmd);
        end
        // a write while busy leaves the buffer alone
        if (tx_write && q.st == TWS_ST_IDLE) begin
            d.tx_buf = tx_data;
        end

        if (q.st == TWS_ST_RUN) begin
            if (slave) begin
                ev_rise = q.rt_s2 != q.rt_p;
                ev_fall = q.ft_s2 != q.ft_p;
            end else if (q.div == half - TWS_DIV_ONE) begin
                d.div   = TWS_DIV_RESET;
                d.sck   = ~q.sck;
                d.nedge = q.nedge + 5'h01;
                ev_rise = !q.sck;
                ev_fall = q.sck;
            end else begin
                d.div = q.div + TWS_DIV_ONE;
            end
        end
        // polarity alone says which edge leads; phase then picks
        // whether the leading edge captures or launches
        ev_lead  = cfg.ckp ? ev_rise : ev_fall;
        ev_trail = cfg.ckp ? ev_fall : ev_rise;
        // phase zero captures on trailing edge
        // phase one captures on leading edge
        ev_cap    = cfg.dap ? ev_lead : ev_trail;
        ev_launch = cfg.dap ? ev_trail : ev_lead;
        if (slave) begin
            si_now = ev_rise ? rise_si : fall_si;
        end else begin
            si_now = q.si_s2;
        end

        case (q.st)
            TWS_ST_IDLE: begin
                if (start) begin
                    d.st     = TWS_ST_RUN;
                    d.active = 1'b1;
                    d.loaded = 1'b0;
                    d.ncap   = '0;
                    d.nedge  = '0;
                    d.div    = TWS_DIV_RESET;
                    // phase one drives first bit at once
                    // taken from tx_data: the buffer only catches the
                    // byte at this same edge
                    if (cfg.dap && cfg.trmd) begin
                        d.out_latch = first_of(tx_data, cfg.dir);
                    end
                end
            end
            TWS_ST_RUN: begin
                // later bits from the shift register
                // no launch after the eighth capture, so the last bit stays
                if (ev_launch && cfg.trmd && q.ncap != TWS_LAST_BIT + 4'h1) begin
                    if (!q.loaded) begin
                        d.out_latch = first_of(q.tx_buf, cfg.dir);
                    end else begin
                        d.out_latch = first_of(q.sio, cfg.dir);
                    end
                end
                if (ev_cap && q.ncap <= TWS_LAST_BIT) begin
                    src      = q.loaded ? q.sio : q.tx_buf;
                    d.sio    = cfg.dir ? {si_now, src[7:1]} : {src[6:0], si_now};
                    d.loaded = 1'b1;
                    d.ncap   = q.ncap + 4'h1;
                end
                // eight captures make a frame
                // master counts toggles so the frame ends with the clock
                // back at its idle level
                if (slave) begin
                    done = ev_cap && q.ncap == TWS_LAST_BIT;
                end else begin
                    done = d.nedge == TWS_MASTER_EDGES && q.nedge != TWS_MASTER_EDGES;
                end
                if (done) begin
                    d.st     = TWS_ST_IDLE;
                    d.active = 1'b0;
                    d.irq    = 1'b1;
                end
            end
            default: begin
                d.st = TWS_ST_IDLE;
            end
        endcase

        // software clear loses to a completion in the same cycle
        if (irq_clear && !done) begin
            d.irq = 1'b0;
        end

        // disable clears engine and shift register
        // the clear takes one system cycle instead of acting at once,
        // so every flop stays on the single clock edge
        if (!cfg.enable) begin
            d.st        = TWS_ST_IDLE;
            d.active    = 1'b0;
            d.sio       = TWS_BYTE_RESET;
            d.out_latch = 1'b0;
            d.loaded    = 1'b0;
            d.ncap      = '0;
            d.nedge     = '0;
            d.div       = TWS_DIV_RESET;
        end

        // idle clock level: high for polarity zero
        if (d.st == TWS_ST_IDLE) begin
            d.sck = ~cfg.ckp;
        end

        // clock pin drives only as enabled master
        d.sck_oe_n = !(cfg.enable && !slave);
        d.so_oe_n  = !(cfg.enable && cfg.trmd);

        // disabled output per phase and order
        // latch keeps last bit after the frame
        if (!cfg.trmd) begin
            d.so = 1'b0;
        end else if (!cfg.enable) begin
            d.so = cfg.dap ? first_of(d.tx_buf, cfg.dir) : 1'b0;
        end else begin
            d.so = d.out_latch;
        end

        // the edge catchers also need link clock edges while rstn is low
        if (!rstn) begin
            d        = '0;
            d.st     = TWS_ST_IDLE;
            d.tx_buf = TWS_BYTE_RESET;
            d.sio    = TWS_BYTE_RESET;
            d.sck    = 1'b1;
            d.sck_oe_n = 1'b1;
            d.so_oe_n  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign serial_shift_register  = q.sio;
    assign transfer_active_flag   = q.active;
    assign transfer_done_irq_flag = q.irq;
    assign serial_clock_out       = q.sck;
    assign serial_clock_oe_n      = q.sck_oe_n;
    assign serial_out_pin         = q.so;
    assign serial_out_oe_n        = q.so_oe_n;

endmodule

`default_nettype wire

// ---- tws_pkg.sv ----
/*
 * tws_pkg: shared constants and carrier types of the three-wire serial port.
 * Assumes a single system clock domain plus the serial clock pin as link clock.
 */
package tws_pkg;

    // frame geometry
    localparam int          TWS_FRAME_BITS = 8;
    localparam logic [3:0]  TWS_LAST_BIT   = 4'h7;
    localparam logic [4:0]  TWS_MASTER_EDGES = 5'h10;

    // clock select codes
    localparam logic [2:0]  TWS_CKS_SLAVE  = 3'h7;

    // mode register field positions
    localparam int          TWS_MODE_ENABLE_POS = 7;
    localparam int          TWS_MODE_TRMD_POS   = 6;
    localparam int          TWS_MODE_DIR_POS    = 4;
    localparam int          TWS_MODE_ACTIVE_POS = 0;

    // reset values and divider step
    localparam logic [7:0]  TWS_BYTE_RESET = 8'h00;
    localparam logic [6:0]  TWS_DIV_RESET  = 7'h00;
    localparam logic [6:0]  TWS_DIV_ONE    = 7'h01;

    typedef enum {
        TWS_ST_IDLE,
        TWS_ST_RUN
    } tws_state_e;

    // configuration as software leaves it before enabling
    typedef struct packed {
        logic       enable;
        logic       trmd;
        logic       dir;
        logic       ckp;
        logic       dap;
        logic [2:0] cks;
    } tws_cfg_s;

    // state of the link-side edge catcher
    typedef struct packed {
        logic tog;
        logic si;
    } tws_link_s;

endpackage

// ---- tws_edge_catch.sv ----
/*
 * tws_edge_catch: link-clock side of the port. On every rising edge of its
 * clock it flips a toggle and samples serial in.
 * Assumes the system side synchronises the toggle before reading the sample;
 * the sample stays put until the next edge of the same kind.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_edge_catch
    import tws_pkg::*;
(
    // link side
    input  wire logic   clk_link,
    input  wire logic   rstn,
    input  wire logic   serial_in_pin,
    // toward the system clock domain
    output logic        tog_o,
    output logic        si_o
);

    tws_link_s q;
    tws_link_s d;

    always_comb begin
        d     = q;
        d.tog = ~q.tog;
        d.si  = serial_in_pin;
        if (!rstn) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_link) begin
        q <= d;
    end

    assign tog_o = q.tog;
    assign si_o  = q.si;

endmodule

`default_nettype wire

// ---- tws_sva.sv ----
/*
 * tws_sva: port checks on the serial port.
 * Assumes configuration only changes while the port is disabled.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_sva
    import tws_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // control
    input wire logic       serial_enable_bit,
    input wire logic       transmit_mode_bit,
    input wire logic       data_phase_bit,
    input wire logic       clock_polarity_bit,
    input wire logic [2:0] clock_select,
    input wire logic       tx_write,
    input wire logic       rx_read,
    // status and pins
    input wire logic [7:0] serial_shift_register,
    input wire logic       transfer_active_flag,
    input wire logic       transfer_done_irq_flag,
    input wire logic       serial_clock_out,
    input wire logic       serial_clock_oe_n,
    input wire logic       serial_out_pin,
    input wire logic       serial_out_oe_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_tx_start: assert property (
        serial_enable_bit && transmit_mode_bit && tx_write && !transfer_active_flag
        |=> transfer_active_flag) else $error("write did not start a frame");
    chk_rx_start: assert property (
        serial_enable_bit && !transmit_mode_bit && rx_read && !transfer_active_flag
        |=> transfer_active_flag) else $error("read did not start a frame");
    chk_done_set: assert property (
        $fell(transfer_active_flag) && serial_enable_bit |-> transfer_done_irq_flag)
        else $error("frame ended without done flag");
    chk_disable_clr: assert property (
        !serial_enable_bit |=> !transfer_active_flag && serial_shift_register == 8'h00)
        else $error("disable did not clear port");
    chk_rx_so_low: assert property (
        !transmit_mode_bit [*2] |-> !serial_out_pin) else $error("serial out not low");
    chk_so_drive: assert property (
        serial_enable_bit && transmit_mode_bit |=> !serial_out_oe_n)
        else $error("serial out not driven");
    chk_slave_clk: assert property (
        clock_select == TWS_CKS_SLAVE |=> serial_clock_oe_n) else $error("slave drives clock");
    chk_sck_quiet: assert property (
        !transfer_active_flag && !$past(transfer_active_flag) && serial_enable_bit
        && $past(serial_enable_bit) && $past(serial_enable_bit, 2)
        |-> $stable(serial_clock_out)) else $error("clock moved outside frame");
    chk_sck_idle: assert property (
        !transfer_active_flag && serial_enable_bit && $past(serial_enable_bit)
        && $past(serial_enable_bit, 2) && clock_select != TWS_CKS_SLAVE
        |-> serial_clock_out == !clock_polarity_bit) else $error("wrong idle clock");
    chk_so_hold: assert property (
        !transfer_active_flag && !$past(transfer_active_flag) && serial_enable_bit
        && $past(serial_enable_bit) && $past(serial_enable_bit, 2) && !data_phase_bit
        |-> $stable(serial_out_pin)) else $error("last bit not held");
endmodule

bind tws_serial_port tws_sva u_sva (
    .clk_sys(clk_sys), .rstn(rstn), .serial_enable_bit(serial_enable_bit),
    .transmit_mode_bit(transmit_mode_bit), .data_phase_bit(data_phase_bit),
    .clock_polarity_bit(clock_polarity_bit), .clock_select(clock_select),
    .tx_write(tx_write), .rx_read(rx_read), .serial_shift_register(serial_shift_register),
    .transfer_active_flag(transfer_active_flag),
    .transfer_done_irq_flag(transfer_done_irq_flag), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n));

`default_nettype wire

// ---- tws_peer.sv ----
/*
 * tws_peer: peripheral on the serial lines, msb first, timing type set by ckp/dap.
 * Assumes load pulses only while the clock line is idle.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_peer (
    // serial lines
    input  wire logic       sck,
    input  wire logic       so,
    output logic            si,
    // bench side
    input  wire logic       ckp,
    input  wire logic       dap,
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    output logic [7:0]      rx_q
);
    logic [7:0] sh_q = 8'h00;
    logic       si_q = 1'b1;
    logic       lead;
    assign si = si_q;
    initial rx_q = 8'h00;
    always @(posedge load or sck) begin
        lead = (sck == ckp);
        if (load) begin
            // no valid bit before the first launch when phase is zero
            si_q <= dap ? load_data[7] : ~load_data[7];
            sh_q <= dap ? {load_data[6:0], 1'b0} : load_data;
        end else if (lead != dap) begin
            si_q <= sh_q[7];
            sh_q <= {sh_q[6:0], ~sh_q[7]};
        end else begin
            rx_q <= {rx_q[6:0], so};
        end
    end
endmodule

`default_nettype wire

// ---- tws_serial_port_tb_top.sv ----
/*
 * tws_serial_port_tb_top: frames in all timing types, both orders, master and slave.
 * Assumes tws_peer on the serial lines and tws_sva bound to the port.
 */
`timescale 1ns/10ps
`default_nettype none

module tws_serial_port_tb_top
    import tws_pkg::*;
;
    typedef struct packed {
        logic [7:0] sio;
        logic [7:0] prx;
        logic       tx;
    } tws_note_s;
    logic       clk_sys = 0, clk_link = 1, rstn = 0, en = 0, trmd = 0, dir = 0, ckp = 0;
    logic       dap = 0, txw = 0, rxr = 0, irqc = 0, load = 0, done_d = 0;
    logic [2:0] cks = 3'h0;
    logic [7:0] txd = 8'h00, pdat = 8'h00, lfsr_q = 8'h38;
    logic [6:0] rows [8] = '{7'h21, 7'h37, 7'h49, 7'h2F, 7'h63, 7'h5D, 7'h30, 7'h70};
    wire logic [7:0] sio, prx;
    wire logic  act, done, sck_o, sck_oe_n, so, so_oe_n, si;
    wire logic  sck_pin = !sck_oe_n ? sck_o : clk_link;
    int         bad_count = 0, check_count = 0, r;
    tws_note_s  note_q[$];
    tws_note_s  n;

    tws_serial_port u_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_link(sck_pin),
        .serial_enable_bit(en), .transmit_mode_bit(trmd), .first_bit_select(dir),
        .clock_polarity_bit(ckp), .data_phase_bit(dap), .clock_select(cks),
        .tx_write(txw), .tx_data(txd), .rx_read(rxr), .irq_clear(irqc),
        .serial_shift_register(sio), .transfer_active_flag(act),
        .transfer_done_irq_flag(done), .serial_in_pin(si), .serial_clock_out(sck_o),
        .serial_clock_oe_n(sck_oe_n), .serial_out_pin(so), .serial_out_oe_n(so_oe_n));
    tws_peer u_peer (.sck(sck_pin), .so(so), .si(si), .ckp(ckp), .dap(dap),
        .load(load), .load_data(pdat), .rx_q(prx));

    initial forever #10 clk_sys = ~clk_sys;

    function automatic logic [7:0] rev(input logic [7:0] x);
        return {<<{x}};
    endfunction
    task tick;
        @(posedge clk_sys);
        #2;
    endtask
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        return lfsr_q;
    endfunction
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task link8;
        #13;
        repeat (8) begin
            #40 clk_link = 0;
            #40 clk_link = 1;
        end
    endtask

    task run(input logic [6:0] cfg, input bit abort);
        logic [7:0] t, p;
        int         i;
        tick;
        {cks, ckp, dap, dir, trmd} = cfg;
        tick;
        en = 1;
        tick;
        t = rnd();
        p = rnd();
        txd = t;
        pdat = p;
        load = 1;
        tick;
        load = 0;
        if (!abort)
            note_q.push_back('{dir ? rev(p) : p, dir ? rev(t) : t, trmd});
        txw = trmd;
        rxr = !trmd;
        tick;
        txw = 0;
        rxr = 0;
        if (cks == TWS_CKS_SLAVE)
            fork link8(); join_none
        if (abort) begin
            repeat (20) tick;
            en = 0;
            tick;
            tick;
            cmp({7'h00, act}, 8'h00);
            cmp(sio, 8'h00);
        end else begin
            // hands off the port until the frame is done
            i = 0;
            while (done !== 1'b1 && i < 5000) begin
                tick;
                i++;
            end
            cmp({7'h00, done}, 8'h01);
            irqc = 1;
            tick;
            irqc = 0;
            tick;
            cmp({7'h00, done}, 8'h00);
            en = 0;
        end
        // polarity back to zero once the port is disabled
        ckp = 0;
        $display("test cfg %h abort %0d done", cfg, abort);
    endtask

    always @(negedge clk_sys) begin
        done_d <= done;
        if (done === 1'b1 && done_d === 1'b0) begin
            if (note_q.size() == 0) begin
                bad_count++;
                $display("MISMATCH at %0t: unexpected frame", $time);
            end else begin
                n = note_q.pop_front();
                cmp(sio, n.sio);
                if (n.tx)
                    cmp(prx, n.prx);
            end
        end
    end

    initial begin
        #100 clk_link = 0;
        #40 clk_link = 1;
        repeat (13) @(posedge clk_sys);
        #2 rstn = 1;
        for (r = 0; r < 8; r++)
            run(rows[r], 1'b0);
        run(7'h49, 1'b1);
        tally_and_finish();
    end

    initial begin
        #400000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
